// ---- core/instruction_cycle_pipeline.sv ----
// Top level of the instruction cycle sequencer and two-stage fetch/execute pipeline.
module instruction_cycle_pipeline
	import cycle_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Oscillator configuration
	input wire logic [1:0] osc_mode,
	// Banking state from the special registers
	input wire logic program_page_select_bit,
	input wire logic [DATA_W-1:0] file_select_pointer,
	// Program memory
	output logic [IP_W-1:0] prog_addr,
	input wire logic [INSTR_W-1:0] prog_data,
	// Data memory
	output logic [DATA_ADDR_W-1:0] data_addr,
	output logic data_rd_en,
	input wire logic [DATA_W-1:0] data_rd_data,
	output logic data_wr_en,
	output logic [DATA_W-1:0] data_wr_data,
	// Execution unit
	output logic [INSTR_W-1:0] instruction_latch,
	output logic exec_valid,
	output logic [DATA_W-1:0] operand,
	input wire logic result_write,
	input wire logic [DATA_W-1:0] result_data,
	input wire logic branch_req,
	input wire logic [PAGE_OFS_W-1:0] branch_target,
	// Phase and clock outputs
	output logic phase_1,
	output logic phase_2,
	output logic phase_3,
	output logic phase_4,
	output logic [IP_W-1:0] instruction_pointer,
	output logic divided_clock_output,
	output logic divided_clock_oe,
	output logic flush
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [IP_W-1:0] ip;
		logic [IP_W-1:0] fetch_addr;
		logic [INSTR_W-1:0] fetch_word;
		logic fetch_valid;
		logic [INSTR_W-1:0] latch;
		logic latch_valid;
		logic branch_pend;
		logic [DATA_W-1:0] operand;
		logic [DATA_W-1:0] wr_data;
		logic wr_pend;
		logic clk_out;
		logic clk_oe;
		logic flushed;
	} state_t;

	localparam state_t STATE_RESET = '{
		ip: RESET_VECTOR,
		fetch_addr: RESET_VECTOR,
		fetch_word: NOP_WORD,
		fetch_valid: 1'b0,
		latch: NOP_WORD,
		latch_valid: 1'b0,
		branch_pend: 1'b0,
		operand: '0,
		wr_data: '0,
		wr_pend: 1'b0,
		clk_out: 1'b0,
		clk_oe: 1'b0,
		flushed: 1'b0
	};

	state_t state_q;
	state_t state_d;

	phase_t phase;
	logic [DATA_ADDR_W-1:0] mapped_addr;
	logic clk_out_mode;
	logic branch_now;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	phase_generator u_phase (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.phase(phase),
		.phase_1(phase_1),
		.phase_2(phase_2),
		.phase_3(phase_3),
		.phase_4(phase_4)
	);

	data_bank_mapper u_bank (
		.file_field(state_q.latch[FILE_ADDR_W-1:0]),
		.file_select_pointer(file_select_pointer),
		.data_addr(mapped_addr),
		.indirect()
	);

	assign clk_out_mode = (osc_mode == OSC_MODE_EXTERNAL_RC) || (osc_mode == OSC_MODE_INTERNAL_OSC);
	// A branch only counts for an instruction that is really executing.
	assign branch_now = branch_req && state_q.latch_valid;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.clk_oe = clk_out_mode;
		unique case (phase)
			PHASE_1: begin
				// The prefetched word moves into execution unless a branch has voided it.
				state_d.latch = state_q.fetch_word;
				state_d.latch_valid = state_q.fetch_valid && !state_q.branch_pend;
				state_d.flushed = state_q.fetch_valid && state_q.branch_pend;
				state_d.branch_pend = 1'b0;
				state_d.fetch_addr = state_q.ip;
				state_d.fetch_valid = 1'b0;
				state_d.ip = state_q.ip + IP_STEP;
				state_d.wr_pend = 1'b0;
				state_d.clk_out = 1'b0;
			end
			PHASE_2: begin
				if (state_q.latch_valid) begin
					state_d.operand = data_rd_data;
				end
			end
			PHASE_3: begin
				state_d.wr_data = result_data;
				state_d.wr_pend = state_q.latch_valid && result_write;
				state_d.clk_out = clk_out_mode;
			end
			PHASE_4: begin
				state_d.fetch_word = prog_data;
				state_d.fetch_valid = 1'b1;
				state_d.wr_pend = 1'b0;
				if (branch_now) begin
					// The target is fetched in the next cycle, so the branch costs one extra cycle.
					state_d.ip = {program_page_select_bit, branch_target};
					state_d.branch_pend = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= STATE_RESET;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prog_addr = state_q.fetch_addr;
	assign instruction_pointer = state_q.ip;
	assign instruction_latch = state_q.latch;
	assign exec_valid = state_q.latch_valid;
	assign operand = state_q.operand;
	assign data_addr = mapped_addr;
	assign data_rd_en = phase_2 && state_q.latch_valid;
	assign data_wr_en = phase_4 && state_q.wr_pend;
	assign data_wr_data = state_q.wr_data;
	assign divided_clock_output = state_q.clk_out;
	assign divided_clock_oe = state_q.clk_oe;
	assign flush = state_q.flushed;

endmodule

// ---- core/cycle_pkg.sv ----
// Shared constants and types for the instruction cycle sequencer and fetch/execute pipeline.
// Functional notes
// - The oscillator clock is divided by four into four non-overlapping phases that make one instruction cycle.
// - The instruction pointer advances once per instruction cycle, in phase 1, which opens a fetch cycle.
// - The word that the instruction pointer addresses is read from program memory and captured in phase 4.
// - In the next cycle that word enters the instruction latch in phase 1 and is executed in phases 2 to 4.
// - An executing instruction reads its data operand in phase 2 and writes its result in phase 4.
// - Fetch of the next instruction overlaps execution of the current one, giving one instruction per cycle.
// - An instruction that changes the instruction pointer, such as a jump, takes two instruction cycles.
// - On a branch the prefetched word is discarded unexecuted while the target is fetched and then executed.
// - In external RC or internal oscillator mode the divided clock output runs at a quarter of the oscillator.
// - The program memory page comes from the page select bit held in the status register.
// - The data memory bank comes from bits of the file select pointer.
// - The instruction pointer is ten bits wide and execution starts at address zero after reset.
package cycle_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int IP_W = 10;
	localparam int PAGE_OFS_W = 9;
	localparam int INSTR_W = 12;
	localparam int DATA_W = 8;
	localparam int FILE_ADDR_W = 5;
	localparam int DATA_ADDR_W = 7;
	localparam int BANK_W = 2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FSR_BANK_LSB = 5;
	localparam int FILE_BANKED_BIT = 4;

	// ----------------------------------------------------------------
	// Reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [IP_W-1:0] RESET_VECTOR = 10'h000;
	localparam logic [IP_W-1:0] IP_STEP = 10'h001;
	localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
	localparam logic [FILE_ADDR_W-1:0] INDIRECT_FILE = 5'h00;
	localparam logic [BANK_W-1:0] SHARED_BANK = 2'h0;
	localparam int PHASES_PER_CYCLE = 4;

	// ----------------------------------------------------------------
	// Oscillator modes
	// ----------------------------------------------------------------
	localparam logic [1:0] OSC_MODE_CRYSTAL = 2'h0;
	localparam logic [1:0] OSC_MODE_EXT_CLOCK = 2'h1;
	localparam logic [1:0] OSC_MODE_EXTERNAL_RC = 2'h2;
	localparam logic [1:0] OSC_MODE_INTERNAL_OSC = 2'h3;

	typedef enum logic [1:0] {
		PHASE_1,
		PHASE_2,
		PHASE_3,
		PHASE_4
	} phase_t;

endpackage

// ---- core/phase_generator.sv ----
// Four-phase sequencer that splits the oscillator into instruction cycles.
module phase_generator
	import cycle_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Phase outputs
	output phase_t phase,
	output logic phase_1,
	output logic phase_2,
	output logic phase_3,
	output logic phase_4
);

	typedef struct packed {
		phase_t phase;
	} state_t;

	state_t state_q;
	state_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q.phase)
			PHASE_1: state_d.phase = PHASE_2;
			PHASE_2: state_d.phase = PHASE_3;
			PHASE_3: state_d.phase = PHASE_4;
			PHASE_4: state_d.phase = PHASE_1;
		endcase
	end

	// Reset parks the sequencer in phase 1, so the first cycle after release is complete.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '{phase: PHASE_1};
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	assign phase = state_q.phase;
	assign phase_1 = (state_q.phase == PHASE_1);
	assign phase_2 = (state_q.phase == PHASE_2);
	assign phase_3 = (state_q.phase == PHASE_3);
	assign phase_4 = (state_q.phase == PHASE_4);

endmodule

// ---- core/data_bank_mapper.sv ----
// Maps the file field of an instruction onto the banked data memory address.
module data_bank_mapper
	import cycle_pkg::*;
(
	// Address sources
	input wire logic [FILE_ADDR_W-1:0] file_field,
	input wire logic [DATA_W-1:0] file_select_pointer,
	// Mapped address
	output logic [DATA_ADDR_W-1:0] data_addr,
	output logic indirect
);

	logic [BANK_W-1:0] bank;

	always_comb begin
		indirect = (file_field == INDIRECT_FILE);
		bank = file_select_pointer[FSR_BANK_LSB +: BANK_W];
		if (indirect) begin
			data_addr = file_select_pointer[DATA_ADDR_W-1:0];
		end else if (file_field[FILE_BANKED_BIT]) begin
			// Only the upper half of the file window is banked; the lower half is shared.
			data_addr = {bank, file_field};
		end else begin
			data_addr = {SHARED_BANK, file_field};
		end
	end

endmodule

// ---- verif/instruction_cycle_pipeline_sva.sv ----
// Concurrent checks on the ports of the instruction cycle pipeline.
module instruction_cycle_pipeline_sva
	import cycle_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Branch request
	input wire logic branch_req,
	input wire logic [PAGE_OFS_W-1:0] branch_target,
	input wire logic program_page_select_bit,
	// Pipeline state
	input wire logic exec_valid,
	input wire logic flush,
	input wire logic [INSTR_W-1:0] instruction_latch,
	input wire logic [IP_W-1:0] instruction_pointer,
	input wire logic [IP_W-1:0] prog_addr,
	// Phases and strobes
	input wire logic phase_1,
	input wire logic phase_2,
	input wire logic phase_3,
	input wire logic phase_4,
	input wire logic data_rd_en,
	input wire logic data_wr_en,
	// Divided clock
	input wire logic divided_clock_output,
	input wire logic divided_clock_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_PHASE_ONEHOT: assert property ($onehot({phase_1, phase_2, phase_3, phase_4}))
		else $error("phases not one-hot");
	AST_PHASE_ORDER: assert property (clk_en && phase_1 |=> phase_2)
		else $error("phase 2 missed");
	AST_RESET_START: assert property ($rose(rst_n) |-> phase_1 && instruction_pointer == RESET_VECTOR)
		else $error("bad start after reset");
	AST_IP_STEP: assert property (clk_en && phase_1 |=> instruction_pointer == 10'($past(instruction_pointer) + IP_STEP))
		else $error("pointer not stepped");
	AST_FETCH_ADDR: assert property (clk_en && phase_1 |=> prog_addr == $past(instruction_pointer))
		else $error("fetch address wrong");
	AST_LATCH_HOLD: assert property (!(clk_en && phase_1) |=> $stable(instruction_latch) && $stable(exec_valid))
		else $error("latch moved outside phase 1");
	AST_READ_SLOT: assert property (data_rd_en == (phase_2 && exec_valid))
		else $error("read strobe misplaced");
	AST_WRITE_SLOT: assert property (data_wr_en |-> phase_4 && exec_valid)
		else $error("write strobe misplaced");
	AST_BRANCH_LOAD: assert property (clk_en && phase_4 && exec_valid && branch_req
		|=> instruction_pointer == {$past(program_page_select_bit), $past(branch_target)})
		else $error("branch target not loaded");
	AST_BRANCH_FLUSH: assert property (clk_en && phase_4 && exec_valid && branch_req ##1 clk_en
		|=> flush && !exec_valid)
		else $error("prefetched word not discarded");
	AST_DIVIDED_CLOCK_OUTPUT: assert property (divided_clock_output == (divided_clock_oe && (phase_4 || phase_1)))
		else $error("divided clock wrong");
	AST_STALL_HOLD: assert property (!clk_en |=> $stable({phase_1, instruction_pointer, prog_addr}))
		else $error("state moved while stalled");
	COV_BRANCH: cover property (phase_4 && exec_valid && branch_req);
	COV_WRITE: cover property (data_wr_en);
	COV_STALL: cover property (!clk_en ##1 !clk_en);
endmodule

bind instruction_cycle_pipeline instruction_cycle_pipeline_sva chk_u (
	.clk(clk),
	.rst_n(rst_n),
	.clk_en(clk_en),
	.branch_req(branch_req),
	.branch_target(branch_target),
	.program_page_select_bit(program_page_select_bit),
	.exec_valid(exec_valid),
	.flush(flush),
	.instruction_latch(instruction_latch),
	.instruction_pointer(instruction_pointer),
	.prog_addr(prog_addr),
	.phase_1(phase_1),
	.phase_2(phase_2),
	.phase_3(phase_3),
	.phase_4(phase_4),
	.data_rd_en(data_rd_en),
	.data_wr_en(data_wr_en),
	.divided_clock_output(divided_clock_output),
	.divided_clock_oe(divided_clock_oe)
);

// ---- verif/instruction_cycle_pipeline_tb_top.sv ----
// Self-checking bench for the instruction cycle pipeline.
module instruction_cycle_pipeline_tb_top
	import cycle_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, clk_en, program_page_select_bit, result_write, branch_req, data_rd_en, data_wr_en;
	logic exec_valid, flush, divided_clock_output, divided_clock_oe, phase_1, phase_2, phase_3, phase_4;
	logic [1:0] osc_mode;
	logic [DATA_W-1:0] file_select_pointer, data_rd_data, data_wr_data, operand, result_data;
	logic [IP_W-1:0] prog_addr, instruction_pointer;
	logic [INSTR_W-1:0] prog_data, instruction_latch;
	logic [DATA_ADDR_W-1:0] data_addr;
	logic [PAGE_OFS_W-1:0] branch_target;
	int errors, check_count, cycles;
	// Program memory answers at once; the word pattern reaches direct, banked and indirect files.
	assign prog_data = {2'h0, prog_addr} ^ 12'h015;
	instruction_cycle_pipeline dut_u (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.osc_mode(osc_mode),
		.program_page_select_bit(program_page_select_bit),
		.file_select_pointer(file_select_pointer),
		.prog_addr(prog_addr),
		.prog_data(prog_data),
		.data_addr(data_addr),
		.data_rd_en(data_rd_en),
		.data_rd_data(data_rd_data),
		.data_wr_en(data_wr_en),
		.data_wr_data(data_wr_data),
		.instruction_latch(instruction_latch),
		.exec_valid(exec_valid),
		.operand(operand),
		.result_write(result_write),
		.result_data(result_data),
		.branch_req(branch_req),
		.branch_target(branch_target),
		.phase_1(phase_1),
		.phase_2(phase_2),
		.phase_3(phase_3),
		.phase_4(phase_4),
		.instruction_pointer(instruction_pointer),
		.divided_clock_output(divided_clock_output),
		.divided_clock_oe(divided_clock_oe),
		.flush(flush)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			errors++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// Helpers and scenarios
	// ----------------------------------------------------------------
	task automatic step();
		@(posedge clk);
		#10;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Entered in phase 2 of the cycle that executes the word at a, left in phase 4.
	task automatic exec_check(input logic [IP_W-1:0] a);
		logic [INSTR_W-1:0] w;
		logic [DATA_W-1:0] d, r;
		w = {2'h0, a} ^ 12'h015;
		d = 8'h30 + a[7:0];
		r = ~d;
		chk(instruction_latch, w);
		chk(exec_valid, 1'b1);
		chk(data_rd_en, 1'b1);
		chk(data_addr, (w[4:0] == 5'h00) ? file_select_pointer[6:0] :
			(w[4] ? {file_select_pointer[6:5], w[4:0]} : {2'h0, w[4:0]}));
		data_rd_data = d;
		result_data = r;
		result_write = 1'b1;
		step();
		chk(operand, d);
		if (a == 10'h001) begin
			clk_en = 1'b0;
			repeat (3) step();
			chk(phase_3, 1'b1);
			clk_en = 1'b1;
		end
		step();
		chk(data_wr_en, 1'b1);
		chk(data_wr_data, r);
		result_write = 1'b0;
	endtask
	task automatic t_reset_divided_clock_output(input logic [1:0] m);
		rst_n = 1'b0;
		osc_mode = m;
		repeat (10) step();
		chk(phase_1, 1'b1);
		chk(instruction_pointer, RESET_VECTOR);
		chk(prog_addr, RESET_VECTOR);
		rst_n = 1'b1;
		step();
		chk(phase_2, 1'b1);
		chk(instruction_pointer, IP_STEP);
		repeat (2) step();
		chk(phase_4, 1'b1);
		chk(divided_clock_output, m[1]);
		chk(divided_clock_oe, m[1]);
		repeat (2) step();
		chk(divided_clock_output, 1'b0);
	endtask
	task automatic t_branch();
		exec_check(10'h004);
		branch_req = 1'b1;
		branch_target = 9'h015;
		program_page_select_bit = 1'b1;
		step();
		branch_req = 1'b0;
		program_page_select_bit = 1'b0;
		step();
		chk(flush, 1'b1);
		chk(exec_valid, 1'b0);
		chk(data_rd_en, 1'b0);
		chk(prog_addr, 10'h215);
		repeat (2) step();
		// Nothing executes in this cycle, so this request must be ignored.
		branch_req = 1'b1;
		branch_target = 9'h0ff;
		step();
		branch_req = 1'b0;
		step();
		exec_check(10'h215);
		repeat (2) step();
		exec_check(10'h216);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk_en = 1'b1;
		program_page_select_bit = 1'b0;
		file_select_pointer = 8'h4b;
		data_rd_data = 8'h00;
		result_write = 1'b0;
		result_data = 8'h00;
		branch_req = 1'b0;
		branch_target = 9'h000;
		for (int m = 0; m < 4; m++) begin
			t_reset_divided_clock_output(m[1:0]);
		end
		for (int a = 0; a < 4; a++) begin
			exec_check(a[IP_W-1:0]);
			repeat (2) step();
		end
		t_branch();
		results();
	end
endmodule
